//--- rtl/bme_exec.sv
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
// Summary of operation
// - bit AND, opcode 67, 3 bytes, 6 cycles; direction bit picks which side is written
// - second byte: 4-bit working register, 3-bit bit index, 1-bit direction in lsb
// - bit compare, opcode 17, 3 bytes, 6 cycles, operands left unchanged
// - compare: zero set when bits equal, sign cleared, other flags kept
// - bit invert, opcode 57, 2 bytes, 4 cycles, only bit b flips
// - invert: zero set if result bit is 0, sign cleared, others kept
// - opcode 77 with lsb 0 clears bit b, 2 bytes, 4 cycles, no flags
// - opcode 77 with lsb 1 sets bit b, 2 bytes, 4 cycles, no flags
// - bit OR, opcode 07, 3 bytes, 6 cycles, same forms and flags as AND
// - two-operand logic writes only the destination bit; source untouched
// - opcode 37 lsb 0 branches relative when tested bit is 0, 10 cycles
// - otherwise fall through to next instruction; branches change no flags
// - flags live in the register at address d5
// - bit AND stores result bit, zero from result, sign cleared
// - opcode 37 lsb 1 branches when tested bit is 1, else falls through
module bme_exec import bme_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int MEM_DEPTH = 256
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic execBusy,
    output logic [15:0] progCounter
);
    typedef enum logic [2:0] {
        EX_IDLE,
        EX_RD_WORK,
        EX_RD_FULL,
        EX_RD_FLAGS,
        EX_WR_DST,
        EX_WR_FLAGS,
        EX_PAD
    } bme_state_t;

    localparam int MEM_AW = $clog2(MEM_DEPTH);

    generate
        if (MEM_DEPTH != 256 || ADDR_W < 5 || ADDR_W > 8) begin : g_bad_param
            $error("bme_exec: register file must hold 256 bytes and ADDR_W be 5..8");
        end
    endgenerate

    bme_instr_t instr;
    bme_decode_t dec;
    bme_state_t state;
    bme_alu_t res;
    logic [3:0] cycleCnt;
    logic [7:0] workBase;
    logic [7:0] regAddr;
    logic [7:0] workVal;
    logic [7:0] fullVal;
    logic [7:0] flagsVal;
    logic illegal;
    logic lastTaken;
    logic ackQ;
    logic errQ;
    logic lastCycle;
    logic [7:0] byteAddr;
    logic setupPhase;
    logic commit;
    logic startReq;
    logic accessErr;
    logic [31:0] readMux;
    logic memWe;
    logic [7:0] memAddr;
    logic [7:0] memWdata;
    logic [7:0] memRdata;
    logic [7:0] workRegAddr;
    logic [15:0] next_pc;

    assign dec = bme_decode(instr.opcode);
    assign byteAddr = 8'(paddr);
    assign setupPhase = psel & ~penable;
    // a write lands only on the edge at which pready is seen high
    assign commit = psel & penable & ackQ;
    assign startReq = commit & pwrite & (byteAddr == OFS_CTRL) & pwdata[CTRL_START];
    assign lastCycle = execBusy & (cycleCnt == dec.cycles - 4'h1);
    assign workRegAddr = {workBase[7:4], instr.workAddr};
    assign pready = ackQ;
    assign pslverr = ackQ & errQ;

    // every transfer gets one wait state so that read data come out of a flip-flop
    always_ff @(posedge clk) begin
        if (srst) begin
            ackQ <= 1'b0;
            errQ <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            if (psel & penable & ~ackQ) begin
                ackQ <= 1'b1;
                errQ <= accessErr;
                prdata <= accessErr ? 32'h00000000 : readMux;
            end else begin
                ackQ <= 1'b0;
                errQ <= 1'b0;
            end
        end
    end

    always_comb begin
        readMux = 32'h00000000;
        accessErr = 1'b0;
        case (byteAddr)
            OFS_INSTR: begin
                readMux = {8'h00, instr};
                accessErr = pwrite & execBusy;
            end
            OFS_CTRL: begin
                accessErr = pwrite & execBusy;
            end
            OFS_STATUS: begin
                readMux[STAT_BUSY] = execBusy;
                readMux[STAT_ILLEGAL] = illegal;
                readMux[STAT_TAKEN] = lastTaken;
            end
            OFS_PC: begin
                readMux = {16'h0000, progCounter};
                accessErr = pwrite & execBusy;
            end
            OFS_WORK_BASE: begin
                readMux = {24'h000000, workBase};
                accessErr = pwrite & execBusy;
            end
            OFS_REG_ADDR: begin
                readMux = {24'h000000, regAddr};
            end
            OFS_REG_DATA: begin
                // the port belongs to the executing instruction while busy
                readMux = {24'h000000, memRdata};
                accessErr = execBusy;
            end
            default: begin
                accessErr = 1'b1;
            end
        endcase
    end

    // software-visible registers
    always_ff @(posedge clk) begin
        if (srst) begin
            instr <= bme_instr_t'(RST_INSTR);
            workBase <= RST_WORK_BASE;
            regAddr <= RST_REG_ADDR;
        end else if (ce) begin
            if (commit & pwrite & ~errQ) begin
                case (byteAddr)
                    OFS_INSTR: instr <= bme_instr_t'(pwdata[23:0]);
                    OFS_WORK_BASE: workBase <= pwdata[7:0];
                    OFS_REG_ADDR: regAddr <= pwdata[7:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // register file port: the executing instruction owns it, else software
    always_comb begin
        memWe = 1'b0;
        memAddr = regAddr;
        memWdata = pwdata[7:0];
        if (execBusy) begin
            case (state)
                EX_RD_WORK: memAddr = workRegAddr;
                EX_RD_FULL: memAddr = instr.jumpOffsetOperand;
                EX_RD_FLAGS: memAddr = FLAGS_REG_ADDR;
                EX_WR_DST: begin
                    memWe = res.dstWe;
                    memAddr = res.dstIsFull ? instr.jumpOffsetOperand : workRegAddr;
                    memWdata = res.dstVal;
                end
                EX_WR_FLAGS: begin
                    memWe = res.flagWe;
                    memAddr = FLAGS_REG_ADDR;
                    memWdata = res.flags;
                end
                default: begin
                end
            endcase
        end else begin
            memWe = commit & pwrite & ~errQ & (byteAddr == OFS_REG_DATA);
        end
    end

    bme_regmem #(
        .DEPTH(MEM_DEPTH),
        .WIDTH(8)
    ) u_regmem (
        .clk(clk),
        .ce(ce),
        .we(memWe),
        .addr(MEM_AW'(memAddr)),
        .wdata(memWdata),
        .rdata(memRdata)
    );

    bme_bitalu u_bitalu (
        .instr(instr),
        .workVal(workVal),
        .fullVal(fullVal),
        .flagsIn(flagsVal),
        .res(res)
    );

    // execution sequencer; the cycle counter, not the state walk, sets the length
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= EX_IDLE;
            execBusy <= 1'b0;
            cycleCnt <= 4'h0;
        end else if (ce) begin
            if (~execBusy) begin
                if (startReq & dec.valid) begin
                    state <= EX_RD_WORK;
                    execBusy <= 1'b1;
                    cycleCnt <= 4'h0;
                end
            end else if (lastCycle) begin
                state <= EX_IDLE;
                execBusy <= 1'b0;
                cycleCnt <= 4'h0;
            end else begin
                cycleCnt <= cycleCnt + 4'h1;
                case (state)
                    EX_RD_WORK: state <= (dec.threeByte & ~dec.branch) ? EX_RD_FULL : EX_RD_FLAGS;
                    EX_RD_FULL: state <= EX_RD_FLAGS;
                    EX_RD_FLAGS: state <= dec.branch ? EX_PAD : EX_WR_DST;
                    EX_WR_DST: state <= EX_WR_FLAGS;
                    EX_WR_FLAGS: state <= EX_PAD;
                    EX_PAD: state <= EX_PAD;
                    default: state <= EX_IDLE;
                endcase
            end
        end
    end

    // operand capture; read data trail the address by one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            workVal <= 8'h00;
            fullVal <= 8'h00;
            flagsVal <= 8'h00;
        end else if (ce & execBusy) begin
            case (state)
                EX_RD_FULL: workVal <= memRdata;
                EX_RD_FLAGS: begin
                    if (dec.threeByte & ~dec.branch) begin
                        fullVal <= memRdata;
                    end else begin
                        workVal <= memRdata;
                    end
                end
                EX_WR_DST: flagsVal <= memRdata;
                default: begin
                end
            endcase
        end
    end

    // pc moves past the instruction; a taken branch also adds the signed offset
    always_comb begin
        next_pc = progCounter + dec.length;
        if (dec.branch & res.taken) begin
            // 16-bit wrap; targets beyond +127/-128 cannot be encoded
            next_pc = next_pc + {{8{instr.jumpOffsetOperand[7]}}, instr.jumpOffsetOperand};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            progCounter <= RST_PC;
            illegal <= 1'b0;
            lastTaken <= 1'b0;
        end else if (ce) begin
            if (lastCycle) begin
                progCounter <= next_pc;
                lastTaken <= dec.branch & res.taken;
            end else if (commit & pwrite & ~errQ & (byteAddr == OFS_PC)) begin
                progCounter <= pwdata[15:0];
            end
            if (startReq & ~execBusy) begin
                illegal <= ~dec.valid;
            end
        end
    end
endmodule

//--- rtl/bme_pkg.sv
package bme_pkg;

    // instruction opcodes
    localparam logic [7:0] OP_BIT_AND = 8'h67;
    localparam logic [7:0] OP_BIT_OR = 8'h07;
    localparam logic [7:0] OP_BIT_COMPARE = 8'h17;
    localparam logic [7:0] OP_BIT_INVERT = 8'h57;
    localparam logic [7:0] OP_BIT_CLEAR_SET = 8'h77;
    localparam logic [7:0] OP_BIT_BRANCH = 8'h37;

    // execution length in core cycles, and instruction length in bytes
    localparam logic [3:0] CYC_TWO_BYTE = 4'h4;
    localparam logic [3:0] CYC_THREE_BYTE = 4'h6;
    localparam logic [3:0] CYC_BRANCH = 4'ha;
    localparam logic [15:0] LEN_TWO_BYTE = 16'h0002;
    localparam logic [15:0] LEN_THREE_BYTE = 16'h0003;

    // flag register and its bit positions
    localparam logic [7:0] FLAGS_REG_ADDR = 8'hd5;
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;

    // apb register byte offsets
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PC = 8'h0c;
    localparam logic [7:0] OFS_WORK_BASE = 8'h10;
    localparam logic [7:0] OFS_REG_ADDR = 8'h14;
    localparam logic [7:0] OFS_REG_DATA = 8'h18;

    // field positions
    localparam int CTRL_START = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ILLEGAL = 1;
    localparam int STAT_TAKEN = 2;

    // reset values
    localparam logic [15:0] RST_PC = 16'h0000;
    localparam logic [7:0] RST_WORK_BASE = 8'hc0;
    localparam logic [23:0] RST_INSTR = 24'h000000;
    localparam logic [7:0] RST_REG_ADDR = 8'h00;

    typedef struct packed {
        logic [7:0] jumpOffsetOperand;
        logic [3:0] workAddr;
        logic [2:0] bitIdx;
        logic lsb;
        logic [7:0] opcode;
    } bme_instr_t;

    typedef struct packed {
        logic valid;
        logic threeByte;
        logic branch;
        logic [3:0] cycles;
        logic [15:0] length;
    } bme_decode_t;

    typedef struct packed {
        logic [7:0] dstVal;
        logic dstWe;
        logic dstIsFull;
        logic [7:0] flags;
        logic flagWe;
        logic taken;
    } bme_alu_t;

    function automatic bme_decode_t bme_decode(input logic [7:0] op);
        bme_decode_t d;
        d = '{valid: 1'b1, threeByte: 1'b1, branch: 1'b0, cycles: CYC_THREE_BYTE,
              length: LEN_THREE_BYTE};
        case (op)
            OP_BIT_AND, OP_BIT_OR, OP_BIT_COMPARE: begin
            end
            OP_BIT_INVERT, OP_BIT_CLEAR_SET: begin
                d.threeByte = 1'b0;
                d.cycles = CYC_TWO_BYTE;
                d.length = LEN_TWO_BYTE;
            end
            OP_BIT_BRANCH: begin
                d.branch = 1'b1;
                d.cycles = CYC_BRANCH;
            end
            default: begin
                d.valid = 1'b0;
            end
        endcase
        return d;
    endfunction

endpackage

//--- rtl/bme_regmem.sv
`timescale 1ns/100ps
module bme_regmem #(
    parameter int DEPTH = 256,
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // contents are not reset, as in a real register file
    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule

//--- rtl/bme_bitalu.sv
`timescale 1ns/100ps
module bme_bitalu import bme_pkg::*; (
    input wire bme_instr_t instr,
    input wire logic [7:0] workVal,
    input wire logic [7:0] fullVal,
    input wire logic [7:0] flagsIn,
    output bme_alu_t res
);
    logic srcBit;
    logic dstBit;
    logic resBit;
    logic [7:0] zsFlags;

    always_comb begin
        srcBit = instr.lsb ? workVal[0] : fullVal[instr.bitIdx];
        dstBit = instr.lsb ? fullVal[instr.bitIdx] : workVal[0];
        resBit = 1'b0;
        zsFlags = flagsIn;
        zsFlags[FLAG_S] = 1'b0;
        res = '0;
        res.flags = flagsIn;
        case (instr.opcode)
            OP_BIT_AND, OP_BIT_OR: begin
                resBit = (instr.opcode == OP_BIT_AND) ? (srcBit & dstBit) : (srcBit | dstBit);
                res.dstWe = 1'b1;
                res.dstIsFull = instr.lsb;
                res.dstVal = instr.lsb ? fullVal : workVal;
                if (instr.lsb) begin
                    res.dstVal[instr.bitIdx] = resBit;
                end else begin
                    res.dstVal[0] = resBit;
                end
                res.flags = zsFlags;
                res.flags[FLAG_Z] = ~resBit;
                res.flagWe = 1'b1;
            end
            OP_BIT_COMPARE: begin
                res.flags = zsFlags;
                res.flags[FLAG_Z] = (workVal[0] == fullVal[instr.bitIdx]);
                res.flagWe = 1'b1;
            end
            OP_BIT_INVERT: begin
                resBit = ~workVal[instr.bitIdx];
                res.dstWe = 1'b1;
                res.dstVal = workVal;
                res.dstVal[instr.bitIdx] = resBit;
                res.flags = zsFlags;
                res.flags[FLAG_Z] = ~resBit;
                res.flagWe = 1'b1;
            end
            OP_BIT_CLEAR_SET: begin
                res.dstWe = 1'b1;
                res.dstVal = workVal;
                res.dstVal[instr.bitIdx] = instr.lsb;
            end
            OP_BIT_BRANCH: begin
                res.taken = instr.lsb ? workVal[instr.bitIdx] : ~workVal[instr.bitIdx];
            end
            default: begin
            end
        endcase
    end
endmodule

//--- sim/bme_exec_chk.sv
`timescale 1ns/100ps
module bme_exec_chk import bme_pkg::*; #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic execBusy,
    input wire logic [15:0] progCounter
);
    logic [7:0] op;
    logic [7:0] third;
    logic [4:0] busyCnt;
    logic [4:0] expCyc;
    logic [15:0] lenPc;
    logic wrDone;
    logic startReq;
    logic validOp;
    assign wrDone = psel && penable && pwrite && pready && !pslverr;
    assign startReq = wrDone && paddr[7:0] == OFS_CTRL && pwdata[0] && !execBusy;
    assign validOp = op inside {OP_BIT_AND, OP_BIT_OR, OP_BIT_COMPARE, OP_BIT_INVERT,
        OP_BIT_CLEAR_SET, OP_BIT_BRANCH};
    assign expCyc = (op == OP_BIT_BRANCH) ? 5'h0a :
        (op == OP_BIT_INVERT || op == OP_BIT_CLEAR_SET) ? 5'h04 : 5'h06;
    assign lenPc = (op == OP_BIT_INVERT || op == OP_BIT_CLEAR_SET) ? LEN_TWO_BYTE : LEN_THREE_BYTE;
    // instr writes are refused while busy, so the snooped opcode is stable during execution
    always_ff @(posedge clk) begin
        if (srst) begin
            op <= 8'h00;
            third <= 8'h00;
        end else if (ce && wrDone && paddr[7:0] == OFS_INSTR) begin
            op <= pwdata[7:0];
            third <= pwdata[23:16];
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            busyCnt <= 5'h00;
        end else if (ce) begin
            busyCnt <= execBusy ? busyCnt + 5'h01 : 5'h00;
        end
    end
    AST_START_BUSY: assert property (@(posedge clk) disable iff (srst || !ce)
        startReq && validOp |=> execBusy) else $error("valid start did not raise busy");
    AST_ILLEGAL_IDLE: assert property (@(posedge clk) disable iff (srst || !ce)
        startReq && !validOp |=> !execBusy) else $error("unsupported opcode executed");
    AST_BUSY_LEN: assert property (@(posedge clk) disable iff (srst || !ce)
        $fell(execBusy) |-> busyCnt == expCyc) else $error("wrong execution length");
    AST_TWO_BYTE_LEN: assert property (@(posedge clk) disable iff (srst || !ce)
        $rose(execBusy) && lenPc == LEN_TWO_BYTE |-> execBusy [*4] ##1 !execBusy)
        else $error("two byte form not four cycles");
    AST_PC_SEQ: assert property (@(posedge clk) disable iff (srst || !ce)
        $fell(execBusy) && op != OP_BIT_BRANCH |-> progCounter == $past(progCounter) + lenPc)
        else $error("pc not advanced by length");
    AST_PC_BRANCH: assert property (@(posedge clk) disable iff (srst || !ce)
        $fell(execBusy) && op == OP_BIT_BRANCH |-> progCounter == $past(progCounter) + 16'h0003
        || progCounter == $past(progCounter) + 16'h0003 + {{8{third[7]}}, third})
        else $error("branch target wrong");
    AST_PC_HOLD: assert property (@(posedge clk) disable iff (srst || !ce)
        execBusy && $past(execBusy) |-> $stable(progCounter)) else $error("pc moved mid-run");
    AST_PC_IDLE: assert property (@(posedge clk) disable iff (srst || !ce)
        !execBusy && !$past(execBusy) && !$past(wrDone && paddr[7:0] == OFS_PC)
        |-> $stable(progCounter)) else $error("pc moved while idle");
endmodule
bind bme_exec bme_exec_chk #(.ADDR_W(ADDR_W)) chk_u (.clk(clk), .srst(srst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .execBusy(execBusy),
    .progCounter(progCounter));

//--- sim/testbench.sv
`timescale 1ns/100ps
module testbench import bme_pkg::*;;
    logic clk, srst, ce, psel, penable, pwrite, pready, pslverr, execBusy, erv;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [15:0] progCounter;
    int num_errors, compares, cycles;
    bme_exec dut_u (.clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .execBusy(execBusy), .progCounter(progCounter));
    always #25 clk = ~clk;
    task automatic end_sim;
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one idle cycle between transfers keeps each request signal to one write per step
    // only the cycle ceiling ends a wait for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic setr(input logic [7:0] a, input logic [7:0] v);
        apb(1'b1, OFS_REG_ADDR, {24'h0, a});
        apb(1'b1, OFS_REG_DATA, {24'h0, v});
    endtask
    task automatic getr(input logic [7:0] a);
        apb(1'b1, OFS_REG_ADDR, {24'h0, a});
        apb(1'b0, OFS_REG_DATA, 32'h0);
    endtask
    task automatic start(input logic [31:0] ins);
        apb(1'b1, OFS_INSTR, ins);
        apb(1'b1, OFS_CTRL, 32'h1);
    endtask
    // busy only shows one edge after the start write lands
    task automatic finish_wait;
        @(posedge clk);
        while (execBusy === 1'b1) begin
            @(posedge clk);
        end
    endtask
    // working register 1 sits at c1, full operand register at 21
    // ew is the expected destination: register 21 for the lsb-1 and/or forms
    task automatic do_op(input logic [7:0] op, input logic lsb, input logic [2:0] b,
        input logic [7:0] third, input logic [7:0] rv, input logic [7:0] fv,
        input logic [7:0] ew, input logic [7:0] ef, input logic [15:0] dpc);
        logic [15:0] pc0;
        logic wideDst;
        wideDst = (op == OP_BIT_AND || op == OP_BIT_OR) && lsb;
        setr(8'hc1, rv);
        setr(8'h21, fv);
        setr(FLAGS_REG_ADDR, 8'hbc);
        pc0 = progCounter;
        start({8'h00, third, 4'h1, b, lsb, op});
        finish_wait();
        chk({16'h0, progCounter}, {16'h0, pc0 + dpc});
        getr(8'hc1);
        chk(rdv, {24'h0, wideDst ? rv : ew});
        getr(8'h21);
        chk(rdv, {24'h0, wideDst ? ew : fv});
        getr(FLAGS_REG_ADDR);
        chk(rdv, {24'h0, ef});
    endtask
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        num_errors = 0;
        compares = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, OFS_PC, 32'h0);
        chk(rdv, 32'h0);
        apb(1'b0, OFS_WORK_BASE, 32'h0);
        chk(rdv, 32'hc0);
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, erv}, 32'h1);
        do_op(OP_BIT_AND, 1'b0, 3'h1, 8'h21, 8'h07, 8'h05, 8'h06, 8'hdc, 16'h3);
        do_op(OP_BIT_AND, 1'b1, 3'h0, 8'h21, 8'h06, 8'h05, 8'h04, 8'hdc, 16'h3);
        do_op(OP_BIT_OR, 1'b0, 3'h1, 8'h21, 8'h06, 8'h03, 8'h07, 8'h9c, 16'h3);
        do_op(OP_BIT_OR, 1'b1, 3'h2, 8'h21, 8'h07, 8'h03, 8'h07, 8'h9c, 16'h3);
        do_op(OP_BIT_COMPARE, 1'b0, 3'h1, 8'h21, 8'h07, 8'h01, 8'h07, 8'h9c, 16'h3);
        do_op(OP_BIT_COMPARE, 1'b0, 3'h1, 8'h21, 8'h07, 8'h02, 8'h07, 8'hdc, 16'h3);
        do_op(OP_BIT_INVERT, 1'b0, 3'h1, 8'h21, 8'h07, 8'h05, 8'h05, 8'hdc, 16'h2);
        do_op(OP_BIT_INVERT, 1'b0, 3'h3, 8'h21, 8'h07, 8'h05, 8'h0f, 8'h9c, 16'h2);
        do_op(OP_BIT_CLEAR_SET, 1'b0, 3'h1, 8'h21, 8'h07, 8'h05, 8'h05, 8'hbc, 16'h2);
        do_op(OP_BIT_CLEAR_SET, 1'b1, 3'h3, 8'h21, 8'h07, 8'h05, 8'h0f, 8'hbc, 16'h2);
        do_op(OP_BIT_BRANCH, 1'b0, 3'h3, 8'h10, 8'h07, 8'h05, 8'h07, 8'hbc, 16'h13);
        do_op(OP_BIT_BRANCH, 1'b1, 3'h1, 8'h80, 8'h07, 8'h05, 8'h07, 8'hbc, 16'hff83);
        do_op(OP_BIT_BRANCH, 1'b1, 3'h3, 8'h7f, 8'h07, 8'h05, 8'h07, 8'hbc, 16'h3);
        do_op(OP_BIT_BRANCH, 1'b0, 3'h1, 8'h10, 8'h07, 8'h05, 8'h07, 8'hbc, 16'h3);
        start({24'h0021, 8'h27});
        repeat (3) @(posedge clk);
        chk({31'h0, execBusy}, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rdv, 32'h2);
        // a low clock enable holds a running bit set where it stands
        start(32'h00001977);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        chk({31'h0, execBusy}, 32'h1);
        ce <= 1'b1;
        finish_wait();
        getr(8'hc1);
        chk(rdv, 32'h17);
        // pc write while a branch runs must be refused and lost
        apb(1'b1, OFS_PC, 32'h3);
        start({8'h00, 8'h05, 8'h13, OP_BIT_BRANCH});
        apb(1'b1, OFS_PC, 32'h1234);
        chk({31'h0, erv}, 32'h1);
        finish_wait();
        chk({16'h0, progCounter}, 32'h000b);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rdv, 32'h4);
        apb(1'b1, OFS_WORK_BASE, 32'h20);
        apb(1'b0, OFS_WORK_BASE, 32'h0);
        chk(rdv, 32'h20);
        end_sim();
    end
endmodule
